// *** hw/txeip_regs.sv ***
// Purpose: Transmit errored-packet insertion control, status, manual error and counters
// Assumes: Synchronous single-cycle register port, reads answered next cycle
// Notes: Rate pacing of errored packets is done by the encoder from err_rate_ctrl
`timescale 1ns/1ns
module txeip_regs
   import txeip_pkg::*;
(
   input wire logic core_clk,
   input wire logic sys_rst,
   input wire txeip_req_type req,
   input wire txeip_evt_type evt,
   output logic [DATA_W-1:0] rdata,
   output logic auto_insert_active,
   output logic [7:0] errored_packet_count_ctrl,
   output logic [7:0] errored_packet_rate_ctrl,
   output logic manual_error_pulse,
   output logic irq
);
   logic initiate_r;
   logic [7:0] ctrl_low_r;
   logic [7:0] err_left_r;
   logic error_insert_finished_r;
   logic finished_prev_r;
   logic error_insert_finished_latched_r;
   logic error_insert_finished_irq_en_r;
   logic manual_error_trigger_r;
   logic tx_monitor_update_request_r;
   logic tx_monitor_update_done_r;
   logic [PKT_CNT_W-1:0] sent_packet_counter_r;
   logic [BYTE_CNT_W-1:0] sent_byte_counter_r;
   logic [PKT_CNT_W-1:0] pkt_snap_r;
   logic [BYTE_CNT_W-1:0] byte_snap_r;
   logic wr_initiate;
   logic run_start;
   logic insert_disabled;
   logic manual_rise;
   logic update_rise;
   logic read_latched;
   logic [DATA_W-1:0] rdata_nxt;

   assign wr_initiate = req.wr && req.addr == ADDR_CTRL_LOW;
   assign run_start = wr_initiate && req.wdata[BIT_INITIATE];
   assign insert_disabled = !initiate_r;
   assign manual_rise = req.wr && req.addr == ADDR_MANUAL_ERR && req.wdata[BIT_MANUAL]
      && !manual_error_trigger_r;
   assign update_rise = req.wr && req.addr == ADDR_MON_UPDATE && req.wdata[BIT_UPDATE]
      && !tx_monitor_update_request_r;
   assign read_latched = req.rd && req.addr == ADDR_STATUS_LATCHED;

   // Control registers written by software
   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         initiate_r <= 1'b0;
         ctrl_low_r <= REG_RESET;
         errored_packet_count_ctrl <= REG_RESET;
         errored_packet_rate_ctrl <= REG_RESET;
         error_insert_finished_irq_en_r <= 1'b0;
         manual_error_trigger_r <= 1'b0;
         tx_monitor_update_request_r <= 1'b0;
      end else if (req.wr) begin
         case (req.addr)
            ADDR_CTRL_LOW: begin
               ctrl_low_r <= req.wdata;
               initiate_r <= req.wdata[BIT_INITIATE];
            end
            ADDR_ERR_COUNT_CTRL: errored_packet_count_ctrl <= req.wdata;
            ADDR_ERR_RATE_CTRL: errored_packet_rate_ctrl <= req.wdata;
            ADDR_IRQ_ENABLE: error_insert_finished_irq_en_r <= req.wdata[BIT_IRQ_EN];
            ADDR_MANUAL_ERR: manual_error_trigger_r <= req.wdata[BIT_MANUAL];
            ADDR_MON_UPDATE: tx_monitor_update_request_r <= req.wdata[BIT_UPDATE];
            default: ;
         endcase
      end
   end

   // Remaining errored-packet budget and finished flag
   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         err_left_r <= REG_RESET;
         error_insert_finished_r <= 1'b0;
      end else if (run_start) begin
         err_left_r <= errored_packet_count_ctrl;
         error_insert_finished_r <= 1'b0;
      end else if (insert_disabled) begin
         error_insert_finished_r <= 1'b0;
         err_left_r <= REG_RESET;
      end else if (evt.errored_pkt_sent && err_left_r != REG_RESET
         && errored_packet_count_ctrl != ERR_COUNT_CONTINUOUS) begin
         err_left_r <= err_left_r - ERR_LEFT_ONE;
         if (err_left_r == ERR_LEFT_ONE)
            error_insert_finished_r <= 1'b1;
      end
   end

   // Insertion still running toward the encoder
   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst)
         auto_insert_active <= 1'b0;
      else
         auto_insert_active <= initiate_r && !error_insert_finished_r
            && (err_left_r != REG_RESET
            || errored_packet_count_ctrl == ERR_COUNT_CONTINUOUS);
   end

   // Latched finished flag, set wins over read clear
   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         finished_prev_r <= 1'b0;
         error_insert_finished_latched_r <= 1'b0;
      end else begin
         finished_prev_r <= error_insert_finished_r;
         if (error_insert_finished_r && !finished_prev_r)
            error_insert_finished_latched_r <= 1'b1;
         else if (read_latched)
            error_insert_finished_latched_r <= 1'b0;
      end
   end

   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst)
         irq <= 1'b0;
      else
         irq <= error_insert_finished_latched_r && error_insert_finished_irq_en_r;
   end

   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst)
         manual_error_pulse <= 1'b0;
      else
         manual_error_pulse <= manual_rise && errored_packet_rate_ctrl[BIT_MODE_SEL];
   end

   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst)
         sent_packet_counter_r <= '0;
      else if (update_rise)
         sent_packet_counter_r <= evt.pkt_sent ? PKT_ONE : '0;
      else if (evt.pkt_sent)
         sent_packet_counter_r <= sent_packet_counter_r + PKT_ONE;
   end

   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst)
         sent_byte_counter_r <= '0;
      else if (update_rise)
         sent_byte_counter_r <= evt.byte_sent ? BYTE_ONE : '0;
      else if (evt.byte_sent)
         sent_byte_counter_r <= sent_byte_counter_r + BYTE_ONE;
   end

   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         pkt_snap_r <= '0;
         byte_snap_r <= '0;
      end else if (update_rise) begin
         pkt_snap_r <= sent_packet_counter_r;
         byte_snap_r <= sent_byte_counter_r;
      end
   end

   // Update-done status
   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst)
         tx_monitor_update_done_r <= 1'b0;
      else if (update_rise)
         tx_monitor_update_done_r <= 1'b1;
      else if (!tx_monitor_update_request_r)
         tx_monitor_update_done_r <= 1'b0;
   end

   // Read mux
   always_comb begin
      rdata_nxt = REG_RESET;
      case (req.addr)
         ADDR_CTRL_LOW: rdata_nxt = ctrl_low_r & ~(8'h01 << BIT_INITIATE);
         ADDR_ERR_COUNT_CTRL: rdata_nxt = errored_packet_count_ctrl;
         ADDR_ERR_RATE_CTRL: rdata_nxt = errored_packet_rate_ctrl;
         ADDR_STATUS: rdata_nxt[BIT_FINISHED] = error_insert_finished_r;
         ADDR_STATUS_LATCHED: rdata_nxt[BIT_FINISHED] = error_insert_finished_latched_r;
         ADDR_IRQ_ENABLE: rdata_nxt[BIT_IRQ_EN] = error_insert_finished_irq_en_r;
         ADDR_PKT_CNT0: rdata_nxt = pkt_snap_r[7:0];
         ADDR_PKT_CNT1: rdata_nxt = pkt_snap_r[15:8];
         ADDR_PKT_CNT2: rdata_nxt = pkt_snap_r[23:16];
         ADDR_BYTE_CNT0: rdata_nxt = byte_snap_r[7:0];
         ADDR_BYTE_CNT1: rdata_nxt = byte_snap_r[15:8];
         ADDR_BYTE_CNT2: rdata_nxt = byte_snap_r[23:16];
         ADDR_BYTE_CNT3: rdata_nxt = byte_snap_r[31:24];
         ADDR_MANUAL_ERR: rdata_nxt[BIT_MANUAL] = manual_error_trigger_r;
         ADDR_MON_UPDATE: rdata_nxt[BIT_UPDATE] = tx_monitor_update_request_r;
         ADDR_MON_STATUS: rdata_nxt[BIT_UPDATE] = tx_monitor_update_done_r;
         default: rdata_nxt = REG_RESET;
      endcase
   end

   // Registered read data
   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst)
         rdata <= REG_RESET;
      else if (req.rd)
         rdata <= rdata_nxt;
   end

   a_latch_on_rise: assert property (@(posedge core_clk) disable iff (sys_rst)
      $rose(error_insert_finished_r) |=> error_insert_finished_latched_r)
      else $error("latched finished not set");
   a_irq_follows: assert property (@(posedge core_clk) disable iff (sys_rst)
      error_insert_finished_latched_r && error_insert_finished_irq_en_r |=> irq)
      else $error("irq missing");
   a_irq_masked: assert property (@(posedge core_clk) disable iff (sys_rst)
      !error_insert_finished_irq_en_r |=> !irq)
      else $error("irq not masked");
   a_finish_clear: assert property (@(posedge core_clk) disable iff (sys_rst)
      run_start || insert_disabled |=> !error_insert_finished_r)
      else $error("finished not cleared");
   a_manual_gate: assert property (@(posedge core_clk) disable iff (sys_rst)
      manual_error_pulse |-> $past(errored_packet_rate_ctrl[BIT_MODE_SEL]))
      else $error("manual error without mode");
   a_manual_single: assert property (@(posedge core_clk) disable iff (sys_rst)
      manual_error_pulse |=> !manual_error_pulse)
      else $error("manual error repeated");
   a_snap_load: assert property (@(posedge core_clk) disable iff (sys_rst)
      update_rise |=> pkt_snap_r == $past(sent_packet_counter_r)
      && tx_monitor_update_done_r)
      else $error("snapshot wrong");
   a_snap_carry: assert property (@(posedge core_clk) disable iff (sys_rst)
      update_rise && evt.byte_sent |=> sent_byte_counter_r == BYTE_ONE)
      else $error("snapshot event lost");
   a_done_clear: assert property (@(posedge core_clk) disable iff (sys_rst)
      !tx_monitor_update_request_r && !update_rise |=> !tx_monitor_update_done_r)
      else $error("done not cleared");
   a_snap_stable: assert property (@(posedge core_clk) disable iff (sys_rst)
      !update_rise |=> $stable(byte_snap_r))
      else $error("snapshot moved");
   a_done_hold: assert property (@(posedge core_clk) disable iff (sys_rst)
      error_insert_finished_r && !run_start && !insert_disabled
      |=> error_insert_finished_r)
      else $error("finished dropped");
   a_latch_hold: assert property (@(posedge core_clk) disable iff (sys_rst)
      error_insert_finished_latched_r && !read_latched |=> error_insert_finished_latched_r)
      else $error("latched finished dropped");
   a_finish_set: assert property (@(posedge core_clk) disable iff (sys_rst)
      evt.errored_pkt_sent && err_left_r == ERR_LEFT_ONE && !run_start && initiate_r
      && errored_packet_count_ctrl != ERR_COUNT_CONTINUOUS |=> error_insert_finished_r)
      else $error("finished not set");
   a_pkt_carry: assert property (@(posedge core_clk) disable iff (sys_rst)
      update_rise && evt.pkt_sent |=> sent_packet_counter_r == PKT_ONE)
      else $error("snapshot packet lost");
   a_byte_snap: assert property (@(posedge core_clk) disable iff (sys_rst)
      update_rise |=> byte_snap_r == $past(sent_byte_counter_r))
      else $error("byte snapshot wrong");
   // live packet counter steps by one
   a_pkt_count: assert property (@(posedge core_clk) disable iff (sys_rst)
      evt.pkt_sent && !update_rise
      |=> sent_packet_counter_r == $past(sent_packet_counter_r) + PKT_ONE)
      else $error("packet count step wrong");
   a_init_reads_zero: assert property (@(posedge core_clk) disable iff (sys_rst)
      req.rd && req.addr == ADDR_CTRL_LOW |=> !rdata[BIT_INITIATE])
      else $error("initiate bit readable");
   // armed manual rise gives one pulse
   sequence s_manual_armed;
      manual_rise && errored_packet_rate_ctrl[BIT_MODE_SEL];
   endsequence
   sequence s_single_pulse;
      manual_error_pulse ##1 !manual_error_pulse;
   endsequence
   a_manual_once: assert property (@(posedge core_clk) disable iff (sys_rst)
      s_manual_armed |=> s_single_pulse)
      else $error("manual error not single");
endmodule : txeip_regs

// *** hw/txeip_pkg.sv ***
// Purpose: Constants and carrier types for the transmit error-insert and monitor registers
// Assumes: 8-bit parallel register port, byte addresses as printed
// Notes: Shared by the register bank and its verification
package txeip_pkg;
   localparam int ADDR_W = 8;
   localparam int DATA_W = 8;
   localparam int PKT_CNT_W = 24;
   localparam int BYTE_CNT_W = 32;
   // Register byte addresses
   localparam logic [7:0] ADDR_CTRL_LOW = 8'hC4;
   localparam logic [7:0] ADDR_ERR_COUNT_CTRL = 8'hC6;
   localparam logic [7:0] ADDR_ERR_RATE_CTRL = 8'hC7;
   localparam logic [7:0] ADDR_STATUS = 8'hC8;
   localparam logic [7:0] ADDR_STATUS_LATCHED = 8'hC9;
   localparam logic [7:0] ADDR_IRQ_ENABLE = 8'hCA;
   localparam logic [7:0] ADDR_PKT_CNT0 = 8'hCC;
   localparam logic [7:0] ADDR_PKT_CNT1 = 8'hCD;
   localparam logic [7:0] ADDR_PKT_CNT2 = 8'hCE;
   localparam logic [7:0] ADDR_BYTE_CNT0 = 8'hD0;
   localparam logic [7:0] ADDR_BYTE_CNT1 = 8'hD1;
   localparam logic [7:0] ADDR_BYTE_CNT2 = 8'hD2;
   localparam logic [7:0] ADDR_BYTE_CNT3 = 8'hD3;
   localparam logic [7:0] ADDR_MANUAL_ERR = 8'hD4;
   localparam logic [7:0] ADDR_MON_UPDATE = 8'hD6;
   localparam logic [7:0] ADDR_MON_STATUS = 8'hD7;
   // Field positions and values
   localparam int BIT_INITIATE = 0;
   localparam int BIT_FINISHED = 0;
   localparam int BIT_IRQ_EN = 0;
   localparam int BIT_MANUAL = 0;
   localparam int BIT_UPDATE = 0;
   localparam int BIT_MODE_SEL = 7;
   localparam logic [7:0] ERR_COUNT_CONTINUOUS = 8'hFF;
   localparam logic [7:0] REG_RESET = 8'h00;
   localparam logic [7:0] ERR_LEFT_ONE = 8'h01;
   localparam logic [23:0] PKT_ONE = 24'h000001;
   localparam logic [31:0] BYTE_ONE = 32'h00000001;

   // Register port request
   typedef struct packed {
      logic rd;
      logic wr;
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] wdata;
   } txeip_req_type;

   // Datapath events from the packet encoder
   typedef struct packed {
      logic pkt_sent;
      logic byte_sent;
      logic errored_pkt_sent;
   } txeip_evt_type;
endpackage : txeip_pkg

// *** test/test_tx_hdlc_error_insert_pmon.sv ***
// Purpose: Self-checking bench for the transmit error-insert and monitor registers
// Assumes: Read data settles one cycle after the read strobe is taken
// Notes: Reads queue their expected byte, a negedge watcher compares the answers
`timescale 1ns/1ns
module test_tx_hdlc_error_insert_pmon
   import txeip_pkg::*;
;
   logic core_clk;
   logic sys_rst;
   txeip_req_type req;
   txeip_evt_type evt;
   logic [DATA_W-1:0] rdata;
   logic auto_insert_active;
   logic [7:0] errored_packet_count_ctrl;
   logic [7:0] errored_packet_rate_ctrl;
   logic manual_error_pulse;
   logic irq;
   logic [7:0] exp_q[$];
   logic rd_d;
   int num_errors = 0;
   int comparisons = 0;
   int cycles = 0;
   int man_cnt = 0;
   integer seed = 74;
   int np;
   int nb;
   logic [7:0] rst_addrs[12] = '{ADDR_STATUS, ADDR_IRQ_ENABLE, ADDR_PKT_CNT0, ADDR_PKT_CNT1,
      ADDR_PKT_CNT2, ADDR_BYTE_CNT0, ADDR_BYTE_CNT1, ADDR_BYTE_CNT2, ADDR_BYTE_CNT3,
      ADDR_MANUAL_ERR, ADDR_MON_UPDATE, ADDR_MON_STATUS};

   txeip_regs dut (
      .core_clk(core_clk), .sys_rst(sys_rst), .req(req), .evt(evt), .rdata(rdata),
      .auto_insert_active(auto_insert_active),
      .errored_packet_count_ctrl(errored_packet_count_ctrl),
      .errored_packet_rate_ctrl(errored_packet_rate_ctrl),
      .manual_error_pulse(manual_error_pulse), .irq(irq)
   );

   // Clock generation, 20 ns period
   initial begin
      core_clk = 1'b0;
      forever #10 core_clk = ~core_clk;
   end

   task tally_and_finish;
      if (num_errors == 0 && comparisons > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask : tally_and_finish

   task check_byte(input logic [7:0] got, input logic [7:0] exp);
      comparisons++;
      if (got !== exp) begin
         num_errors++;
         $display("Error at %0t: got %0h expected %0h", $time, got, exp);
      end
   endtask : check_byte

   task check_bit(input logic got, input logic exp);
      comparisons++;
      if (got !== exp) begin
         num_errors++;
         $display("Error at %0t: got %0h expected %0h", $time, got, exp);
      end
   endtask : check_bit

   // Register port write, one idle cycle after
   task wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge core_clk);
      req <= '{rd: 1'b0, wr: 1'b1, addr: a, wdata: d};
      @(posedge core_clk);
      req <= '0;
   endtask : wr

   // Register port read, expected byte noted first
   task rd(input logic [7:0] a, input logic [7:0] e);
      @(posedge core_clk);
      exp_q.push_back(e);
      req <= '{rd: 1'b1, wr: 1'b0, addr: a, wdata: 8'h00};
      @(posedge core_clk);
      req <= '0;
   endtask : rd

   task pulse(input txeip_evt_type e, input int n);
      repeat (n) begin
         @(posedge core_clk);
         evt <= e;
         @(posedge core_clk);
         evt <= '0;
      end
   endtask : pulse

   task settle;
      repeat (4) @(posedge core_clk);
      @(negedge core_clk);
   endtask : settle

   // Reads all seven snapshot bytes, low byte first
   task rd_cnt(input logic [23:0] p, input logic [31:0] b);
      for (int i = 0; i < 3; i++) rd(8'(ADDR_PKT_CNT0 + i), p[8*i+:8]);
      for (int i = 0; i < 4; i++) rd(8'(ADDR_BYTE_CNT0 + i), b[8*i+:8]);
   endtask : rd_cnt

   // Answer watcher, one read answer per taken read
   always @(posedge core_clk) rd_d <= req.rd;
   always @(negedge core_clk) begin
      if (rd_d === 1'b1) check_byte(rdata, exp_q.pop_front());
   end

   // Manual error pulse counter and hang guard
   always @(posedge core_clk) begin
      if (manual_error_pulse === 1'b1) man_cnt++;
      cycles++;
      if (cycles == 4000) begin
         num_errors++;
         tally_and_finish();
      end
   end

   initial begin
      sys_rst = 1'b1;
      req = '0;
      evt = '0;
      repeat (6) @(posedge core_clk);
      sys_rst <= 1'b0;
      foreach (rst_addrs[i]) rd(rst_addrs[i], REG_RESET);
      rd(8'hC0, 8'h00);
      // Automatic run of three errored packets
      wr(ADDR_ERR_COUNT_CTRL, 8'h03);
      wr(ADDR_ERR_RATE_CTRL, 8'h01);
      wr(ADDR_CTRL_LOW, 8'h01);
      settle();
      check_bit(auto_insert_active, 1'b1);
      check_byte(errored_packet_count_ctrl, 8'h03);
      rd(ADDR_CTRL_LOW, 8'h00);
      pulse(txeip_evt_type'(3'b001), 2);
      settle();
      rd(ADDR_STATUS, 8'h00);
      pulse(txeip_evt_type'(3'b001), 1);
      settle();
      rd(ADDR_STATUS, 8'h01);
      @(negedge core_clk);
      check_bit(irq, 1'b0);
      check_bit(auto_insert_active, 1'b0);
      wr(ADDR_IRQ_ENABLE, 8'h01);
      settle();
      check_bit(irq, 1'b1);
      rd(ADDR_STATUS_LATCHED, 8'h01);
      rd(ADDR_STATUS_LATCHED, 8'h00);
      settle();
      check_bit(irq, 1'b0);
      // Fresh run, then disable
      wr(ADDR_CTRL_LOW, 8'h01);
      settle();
      rd(ADDR_STATUS, 8'h00);
      rd(ADDR_STATUS_LATCHED, 8'h00);
      pulse(txeip_evt_type'(3'b001), 3);
      settle();
      rd(ADDR_STATUS, 8'h01);
      wr(ADDR_CTRL_LOW, 8'h00);
      settle();
      rd(ADDR_STATUS, 8'h00);
      rd(ADDR_STATUS_LATCHED, 8'h01);
      // Cleanup, then continuous count never finishes
      wr(ADDR_ERR_RATE_CTRL, 8'h00);
      wr(ADDR_ERR_COUNT_CTRL, ERR_COUNT_CONTINUOUS);
      wr(ADDR_CTRL_LOW, 8'h01);
      pulse(txeip_evt_type'(3'b001), 4);
      settle();
      rd(ADDR_STATUS, 8'h00);
      wr(ADDR_ERR_COUNT_CTRL, 8'h00);
      wr(ADDR_CTRL_LOW, 8'h00);
      // Manual error with and without mode select
      wr(ADDR_ERR_RATE_CTRL, 8'h81);
      wr(ADDR_MANUAL_ERR, 8'h01);
      wr(ADDR_MANUAL_ERR, 8'h01);
      settle();
      check_byte(8'(man_cnt), 8'h01);
      check_byte(errored_packet_rate_ctrl, 8'h81);
      rd(ADDR_MANUAL_ERR, 8'h01);
      wr(ADDR_MANUAL_ERR, 8'h00);
      wr(ADDR_ERR_RATE_CTRL, 8'h00);
      wr(ADDR_MANUAL_ERR, 8'h01);
      settle();
      check_byte(8'(man_cnt), 8'h01);
      // Random traffic, snapshot with an event on the update cycle
      np = 1 + ($random(seed) & 15);
      nb = np + ($random(seed) & 31);
      for (int i = 0; i < nb; i++) pulse(txeip_evt_type'({i < np, 1'b1, 1'b0}), 1);
      fork
         wr(ADDR_MON_UPDATE, 8'h01);
         pulse(txeip_evt_type'(3'b110), 1);
      join
      settle();
      rd(ADDR_MON_STATUS, 8'h01);
      rd_cnt(24'(np), 32'(nb));
      pulse(txeip_evt_type'(3'b110), 5);
      rd_cnt(24'(np), 32'(nb));
      wr(ADDR_MON_UPDATE, 8'h00);
      settle();
      rd(ADDR_MON_STATUS, 8'h00);
      wr(ADDR_MON_UPDATE, 8'h01);
      settle();
      rd_cnt(24'h000006, 32'h00000006);
      rd(ADDR_MON_STATUS, 8'h01);
      repeat (3) @(posedge core_clk);
      tally_and_finish();
   end
endmodule : test_tx_hdlc_error_insert_pmon
